// *** verilog/sirst_pkg.sv ***
// Constants, types and register map for the software interrupt/reset unit.
// Assumes one core clock domain; every user-side input comes from logic
// on that clock.
package sirst_pkg;

	// Instruction encoding
	localparam logic [7:0] OP_SWI       = 8'h95;
	localparam logic [7:0] OP_SWRST     = 8'h94;
	localparam int         SWI_ZERO_BIT = 7;
	localparam int         IDX_W        = 5;
	localparam int         HOST_SEL_BIT = 4;
	localparam int         ADDR_W       = 24;

	// Status word and control register fields
	localparam int GLOBAL_IRQ_MASK_BIT   = 11;
	localparam int ST0_TOP_LO = 9;
	localparam int ST0_TOP_W  = 7;
	localparam int CTRL_FAST  = 0;
	localparam int CTRL_BUSY  = 1;

	// Reset values, hardware and software reset
	localparam logic [15:0] ST0_SWRST = 16'h3800;
	localparam logic [15:0] ST1_SWRST = 16'h2920;
	localparam logic [15:0] ST2_SWRST = 16'h1000;
	localparam logic [15:0] ST3_RST   = 16'h0000;
	localparam logic [15:0] IVP_RST   = 16'h0000;
	localparam logic [15:0] SP_RST    = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONE  = 16'h0001;

	// Avalon byte offsets
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_ST0    = 6'h04;
	localparam logic [5:0] OFS_ST1    = 6'h08;
	localparam logic [5:0] OFS_ST2    = 6'h0C;
	localparam logic [5:0] OFS_ST3    = 6'h10;
	localparam logic [5:0] OFS_IRQ_FLAG_REG_LOW   = 6'h14;
	localparam logic [5:0] OFS_IRQ_FLAG_REG_HIGH   = 6'h18;
	localparam logic [5:0] OFS_VECTOR_PTR_DSP   = 6'h1C;
	localparam logic [5:0] OFS_VECTOR_PTR_HOST   = 6'h20;
	localparam logic [5:0] OFS_DBG    = 6'h24;
	localparam logic [5:0] OFS_RETPR  = 6'h28;
	localparam logic [5:0] OFS_T2     = 6'h2C;
	localparam logic [5:0] OFS_SP     = 6'h30;
	localparam logic [5:0] OFS_SSP    = 6'h34;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACC  = 3'b010,
		ST_READ = 3'b011,
		ST_VEC  = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic [15:0]       opcode;
		logic [ADDR_W-1:0] pc;
		logic [7:0]        loop_ctx;
		logic              repeat_on;
		logic              parallel_on;
	} dec_req_t;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [15:0] data;
	} stack_wr_t;

endpackage

// *** verilog/soft_interrupt_reset_unit.sv ***
// Software interrupt and software reset sequencer with Avalon-MM registers.
// Assumes decode, stacks and vector memory run on clk_sys; the vector read
// answers with vec_rd_valid while vec_rd_req is held.
//
// Contract
// - Decode two-byte interrupt, index low, three phases
// - Set irq mask after second status push
// - Vector address from pointer plus index
// - Interrupt runs regardless of irq mask
// - Address phase: data stack gets word two
// - Address phase: system stack gets word-zero top
// - Access phase: data stack gets word one
// - Access phase: system stack gets debug context
// - Read phase: data stack gets return low
// - Read phase: system stack loop plus high
// - Load routine address, clear flow context
// - Acknowledge clears the one pending flag bit matching the index
// - Neither instruction accepted under repeat
// - Fast return saves into paired registers
// - Default slow return pushes onto stacks
// - Decode two-byte reset, second byte ignored
// - Reset status words, flags, temp two
// - Reset sets irq mask, clears flags
// - Vector pointers, word three left alone
// - Status word one reset values
// - Status word zero reset values
// - Status word two reset values
// - Temp register two cleared on reset
module soft_interrupt_reset_unit (
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic [5:0]                   address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [3:0]                   byteenable,
	input  wire logic [31:0]                  writedata,
	output logic [31:0]                       readdata,
	output logic                              waitrequest,
	input  wire logic                         dec_valid,
	input  wire sirst_pkg::dec_req_t          dec_req,
	output logic                              dec_ready,
	input  wire logic [31:0]                  irq_raise,
	output logic                              vec_rd_req,
	output logic [sirst_pkg::ADDR_W-1:0]      vec_rd_addr,
	input  wire logic                         vec_rd_valid,
	input  wire logic [sirst_pkg::ADDR_W-1:0] vec_rd_data,
	output sirst_pkg::stack_wr_t              data_stack_wr,
	output sirst_pkg::stack_wr_t              sys_stack_wr,
	output logic                              pc_load_valid,
	output logic [sirst_pkg::ADDR_W-1:0]      pc_load_addr,
	output logic                              flow_ctx_clear,
	output logic                              repeat_refused,
	output logic                              sw_reset_done,
	output logic                              global_irq_mask,
	output logic [15:0]                       status_word_zero,
	output logic [15:0]                       status_word_one,
	output logic [15:0]                       status_word_two,
	output logic [15:0]                       status_word_three,
	output logic [15:0]                       temp_reg_two
);

	function automatic logic [15:0] merge16(
		input logic [15:0] old_v,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		merge16 = old_v;
		if (be[0])
			merge16[7:0] = wd[7:0];
		if (be[1])
			merge16[15:8] = wd[15:8];
	endfunction

	sirst_pkg::seq_state_t state_r;
	logic [15:0]           st0_r, st1_r, st2_r, st3_r, t2_r;
	logic [15:0]           ifr_low_r, ifr_high_r;
	logic [15:0]           vector_ptr_dsp_r, vector_ptr_host_r, dbg_r;
	logic [15:0]           sp_r, ssp_r;
	logic [23:0]           return_addr_reg_r;
	logic [7:0]            flow_context_reg_r;
	logic                  fast_ret_r;
	logic                  ack_r;
	logic [31:0]           rdata_r;
	logic [23:0]           ret_pc_r;
	logic [7:0]            loop_r;
	logic [4:0]            idx_r;
	sirst_pkg::stack_wr_t  dstk_r, sstk_r;
	logic                  vec_req_r, pc_ld_r, flow_clr_r;
	logic                  refused_r, swrst_r;
	logic [23:0]           vec_addr_r, pc_addr_r;

	logic        dec_fire, is_swi, is_rst, bad_ctx;
	logic        swi_go, rst_go, wr_go, vec_done;
	logic [31:0] ifr_clr;

	// Decode stalls while a sequence runs
	// stall decode when busy
	assign dec_ready = (state_r == sirst_pkg::ST_IDLE);
	assign dec_fire  = dec_valid & dec_ready;
	assign is_swi = (dec_req.opcode[15:8] == sirst_pkg::OP_SWI)
		& ~dec_req.opcode[sirst_pkg::SWI_ZERO_BIT];
	assign is_rst = (dec_req.opcode[15:8] == sirst_pkg::OP_SWRST);
	assign bad_ctx = dec_req.repeat_on | dec_req.parallel_on;
	assign swi_go   = dec_fire & is_swi & ~bad_ctx;
	assign rst_go   = dec_fire & is_rst & ~bad_ctx;
	assign wr_go    = write & ack_r;
	assign vec_done = (state_r == sirst_pkg::ST_VEC) & vec_rd_valid;

	// Bus answer: one wait cycle, then data
	assign waitrequest = (read | write) & ~ack_r;
	assign readdata    = rdata_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= (read | write) & ~ack_r;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (read & ~ack_r) begin
			rdata_r <= 32'h00000000;
			case (address)
				sirst_pkg::OFS_CTRL: begin
					rdata_r[sirst_pkg::CTRL_FAST] <= fast_ret_r;
					rdata_r[sirst_pkg::CTRL_BUSY] <= ~dec_ready;
				end
				sirst_pkg::OFS_ST0:   rdata_r[15:0] <= st0_r;
				sirst_pkg::OFS_ST1:   rdata_r[15:0] <= st1_r;
				sirst_pkg::OFS_ST2:   rdata_r[15:0] <= st2_r;
				sirst_pkg::OFS_ST3:   rdata_r[15:0] <= st3_r;
				sirst_pkg::OFS_IRQ_FLAG_REG_LOW:  rdata_r[15:0] <= ifr_low_r;
				sirst_pkg::OFS_IRQ_FLAG_REG_HIGH:  rdata_r[15:0] <= ifr_high_r;
				sirst_pkg::OFS_VECTOR_PTR_DSP:  rdata_r[15:0] <= vector_ptr_dsp_r;
				sirst_pkg::OFS_VECTOR_PTR_HOST:  rdata_r[15:0] <= vector_ptr_host_r;
				sirst_pkg::OFS_DBG:   rdata_r[15:0] <= dbg_r;
				sirst_pkg::OFS_RETPR: rdata_r <= {flow_context_reg_r, return_addr_reg_r};
				sirst_pkg::OFS_T2:    rdata_r[15:0] <= t2_r;
				sirst_pkg::OFS_SP:    rdata_r[15:0] <= sp_r;
				sirst_pkg::OFS_SSP:   rdata_r[15:0] <= ssp_r;
				default:              rdata_r <= 32'h00000000;
			endcase
		end
	end

	// Sequencer: address, access, read phases, then vector fetch
	// three decode-phase cycles
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= sirst_pkg::ST_IDLE;
		end else begin
			case (state_r)
				sirst_pkg::ST_IDLE:
					if (swi_go)
						state_r <= sirst_pkg::ST_ADDR;
				sirst_pkg::ST_ADDR: state_r <= sirst_pkg::ST_ACC;
				sirst_pkg::ST_ACC:  state_r <= sirst_pkg::ST_READ;
				sirst_pkg::ST_READ: state_r <= sirst_pkg::ST_VEC;
				sirst_pkg::ST_VEC:
					if (vec_rd_valid)
						state_r <= sirst_pkg::ST_IDLE;
				default: state_r <= sirst_pkg::ST_IDLE;
			endcase
		end
	end

	// Context captured at acceptance
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ret_pc_r <= 24'h000000;
			loop_r   <= 8'h00;
			idx_r    <= 5'h00;
		end else if (swi_go) begin
			ret_pc_r <= dec_req.pc;
			loop_r   <= dec_req.loop_ctx;
			idx_r    <= dec_req.opcode[sirst_pkg::IDX_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			fast_ret_r <= 1'b0;
		else if (wr_go && address == sirst_pkg::OFS_CTRL && byteenable[0])
			fast_ret_r <= writedata[sirst_pkg::CTRL_FAST];
	end

	// Hardware updates win over a same-cycle bus write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st0_r <= sirst_pkg::ST0_SWRST;
			st2_r <= sirst_pkg::ST2_SWRST;
			t2_r  <= sirst_pkg::WORD_ZERO;
		end else if (rst_go) begin
			st0_r <= sirst_pkg::ST0_SWRST;
			st2_r <= sirst_pkg::ST2_SWRST;
			t2_r  <= sirst_pkg::WORD_ZERO;
		end else if (wr_go) begin
			if (address == sirst_pkg::OFS_ST0)
				st0_r <= merge16(st0_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_ST2)
				st2_r <= merge16(st2_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_T2)
				t2_r <= merge16(t2_r, writedata, byteenable);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st1_r <= sirst_pkg::ST1_SWRST;
		end else if (rst_go) begin
			st1_r <= sirst_pkg::ST1_SWRST;
		end else if (state_r == sirst_pkg::ST_ACC) begin
			// mask set after word one push
			st1_r[sirst_pkg::GLOBAL_IRQ_MASK_BIT] <= 1'b1;
		end else if (wr_go && address == sirst_pkg::OFS_ST1) begin
			st1_r <= merge16(st1_r, writedata, byteenable);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st3_r  <= sirst_pkg::ST3_RST;
			vector_ptr_dsp_r <= sirst_pkg::IVP_RST;
			vector_ptr_host_r <= sirst_pkg::IVP_RST;
			dbg_r  <= sirst_pkg::WORD_ZERO;
		end else if (wr_go) begin
			if (address == sirst_pkg::OFS_ST3)
				st3_r <= merge16(st3_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_VECTOR_PTR_DSP)
				vector_ptr_dsp_r <= merge16(vector_ptr_dsp_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_VECTOR_PTR_HOST)
				vector_ptr_host_r <= merge16(vector_ptr_host_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_DBG)
				dbg_r <= merge16(dbg_r, writedata, byteenable);
		end
	end

	// Pending flags: set always wins over any clear
	always_comb begin
		ifr_clr = 32'h00000000;
		if (rst_go)
			ifr_clr = 32'hFFFFFFFF;
		if (vec_done)
			ifr_clr[idx_r] = 1'b1;
		if (wr_go && address == sirst_pkg::OFS_IRQ_FLAG_REG_LOW)
			ifr_clr[15:0] = ifr_clr[15:0]
				| merge16(16'h0000, writedata, byteenable);
		if (wr_go && address == sirst_pkg::OFS_IRQ_FLAG_REG_HIGH)
			ifr_clr[31:16] = ifr_clr[31:16]
				| merge16(16'h0000, writedata, byteenable);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ifr_low_r  <= sirst_pkg::WORD_ZERO;
			ifr_high_r <= sirst_pkg::WORD_ZERO;
		end else begin
			ifr_low_r  <= (ifr_low_r & ~ifr_clr[15:0]) | irq_raise[15:0];
			ifr_high_r <= (ifr_high_r & ~ifr_clr[31:16])
				| irq_raise[31:16];
		end
	end

	// Stack pointers pre-decrement before every push
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sp_r  <= sirst_pkg::SP_RST;
			ssp_r <= sirst_pkg::SP_RST;
		end else if (swi_go || state_r == sirst_pkg::ST_ADDR
			|| (state_r == sirst_pkg::ST_ACC && !fast_ret_r)) begin
			sp_r  <= sp_r - sirst_pkg::WORD_ONE;
			ssp_r <= ssp_r - sirst_pkg::WORD_ONE;
		end else if (wr_go) begin
			if (address == sirst_pkg::OFS_SP)
				sp_r <= merge16(sp_r, writedata, byteenable);
			if (address == sirst_pkg::OFS_SSP)
				ssp_r <= merge16(ssp_r, writedata, byteenable);
		end
	end

	// Each push shows for one cycle, in its own phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dstk_r <= '0;
			sstk_r <= '0;
		end else begin
			dstk_r.we <= 1'b0;
			sstk_r.we <= 1'b0;
			dstk_r.addr <= sp_r - sirst_pkg::WORD_ONE;
			sstk_r.addr <= ssp_r - sirst_pkg::WORD_ONE;
			if (swi_go) begin
				dstk_r.we   <= 1'b1;
				dstk_r.data <= st2_r;
				sstk_r.we   <= 1'b1;
				sstk_r.data <= {st0_r[15:sirst_pkg::ST0_TOP_LO], 9'h000};
			end else if (state_r == sirst_pkg::ST_ADDR) begin
				dstk_r.we   <= 1'b1;
				dstk_r.data <= st1_r;
				sstk_r.we   <= 1'b1;
				sstk_r.data <= dbg_r;
			end else if (state_r == sirst_pkg::ST_ACC && !fast_ret_r) begin
				dstk_r.we   <= 1'b1;
				dstk_r.data <= ret_pc_r[15:0];
				sstk_r.we   <= 1'b1;
				sstk_r.data <= {loop_r, ret_pc_r[23:16]};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			return_addr_reg_r <= 24'h000000;
			flow_context_reg_r <= 8'h00;
		end else if (state_r == sirst_pkg::ST_ACC && fast_ret_r) begin
			return_addr_reg_r <= ret_pc_r;
			flow_context_reg_r <= loop_r;
		end else if (wr_go && address == sirst_pkg::OFS_RETPR
			&& byteenable == 4'hF) begin
			// Pair written whole only, never half-updated
			return_addr_reg_r <= writedata[23:0];
			flow_context_reg_r <= writedata[31:24];
		end
	end

	// Vector fetch held until the memory answers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vec_req_r  <= 1'b0;
			vec_addr_r <= 24'h000000;
		end else if (state_r == sirst_pkg::ST_READ) begin
			vec_req_r <= 1'b1;
			if (idx_r[sirst_pkg::HOST_SEL_BIT])
				vec_addr_r <= {vector_ptr_host_r, idx_r, 3'h0};
			else
				vec_addr_r <= {vector_ptr_dsp_r, idx_r, 3'h0};
		end else if (vec_done) begin
			vec_req_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_ld_r    <= 1'b0;
			pc_addr_r  <= 24'h000000;
			flow_clr_r <= 1'b0;
			refused_r  <= 1'b0;
			swrst_r    <= 1'b0;
		end else begin
			pc_ld_r    <= vec_done;
			flow_clr_r <= vec_done;
			if (vec_done)
				pc_addr_r <= vec_rd_data;
			refused_r <= dec_fire & (is_swi | is_rst) & bad_ctx;
			swrst_r   <= rst_go;
		end
	end

	assign vec_rd_req        = vec_req_r;
	assign vec_rd_addr       = vec_addr_r;
	assign data_stack_wr     = dstk_r;
	assign sys_stack_wr      = sstk_r;
	assign pc_load_valid     = pc_ld_r;
	assign pc_load_addr      = pc_addr_r;
	assign flow_ctx_clear    = flow_clr_r;
	assign repeat_refused    = refused_r;
	assign sw_reset_done     = swrst_r;
	assign global_irq_mask   = st1_r[sirst_pkg::GLOBAL_IRQ_MASK_BIT];
	assign status_word_zero  = st0_r;
	assign status_word_one   = st1_r;
	assign status_word_two   = st2_r;
	assign status_word_three = st3_r;
	assign temp_reg_two      = t2_r;

endmodule

// *** bench/sirst_chk.sv ***
// Assertions on the software interrupt/reset unit's ports.
// Assumes one clock, clk_sys, and asynchronous active-high rst.
module sirst_chk (
	input wire logic                         clk_sys,
	input wire logic                         rst,
	input wire logic                         dec_valid,
	input wire sirst_pkg::dec_req_t          dec_req,
	input wire logic                         dec_ready,
	input wire logic                         vec_rd_req,
	input wire logic [sirst_pkg::ADDR_W-1:0] vec_rd_addr,
	input wire logic                         vec_rd_valid,
	input wire logic [sirst_pkg::ADDR_W-1:0] vec_rd_data,
	input wire sirst_pkg::stack_wr_t         data_stack_wr,
	input wire sirst_pkg::stack_wr_t         sys_stack_wr,
	input wire logic                         pc_load_valid,
	input wire logic [sirst_pkg::ADDR_W-1:0] pc_load_addr,
	input wire logic                         flow_ctx_clear,
	input wire logic                         repeat_refused,
	input wire logic                         sw_reset_done,
	input wire logic                         global_irq_mask,
	input wire logic [15:0]                  status_word_zero,
	input wire logic [15:0]                  status_word_one,
	input wire logic [15:0]                  status_word_two,
	input wire logic [15:0]                  status_word_three,
	input wire logic [15:0]                  temp_reg_two
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       acc, swi_op, rst_op, plain, swi_acc, rst_acc, bad_acc;
	logic [4:0] idx_r;
	assign acc = dec_valid && dec_ready;
	assign swi_op = dec_req.opcode[15:8] == 8'h95 && !dec_req.opcode[7];
	assign rst_op = dec_req.opcode[15:8] == 8'h94;
	assign plain = !dec_req.repeat_on && !dec_req.parallel_on;
	assign swi_acc = acc && swi_op && plain;
	assign rst_acc = acc && rst_op && plain;
	assign bad_acc = acc && (swi_op || rst_op) && !plain;
	// Index kept for the vector address check
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			idx_r <= 5'h00;
		else if (swi_acc)
			idx_r <= dec_req.opcode[4:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_first_push: assert property (swi_acc |=>
		data_stack_wr.we && sys_stack_wr.we &&
		data_stack_wr.data == $past(status_word_two) &&
		sys_stack_wr.data == {$past(status_word_zero[15:9]), 9'h000})
		else $error("first push wrong");
	a_data_step: assert property (
		data_stack_wr.we && $past(data_stack_wr.we) |->
		data_stack_wr.addr == $past(data_stack_wr.addr) - 16'h0001)
		else $error("data stack step wrong");
	a_sys_step: assert property (
		sys_stack_wr.we && $past(sys_stack_wr.we) |->
		sys_stack_wr.addr == $past(sys_stack_wr.addr) - 16'h0001)
		else $error("system stack step wrong");
	a_mask_after: assert property (swi_acc |=> ##1
		data_stack_wr.data == $past(status_word_one, 2) ##1 global_irq_mask)
		else $error("mask set out of order");
	a_stall_seq: assert property (swi_acc |=> !dec_ready [*4])
		else $error("decode not stalled");
	a_vec_index: assert property ($rose(vec_rd_req) |->
		vec_rd_addr[7:0] == {idx_r, 3'h0})
		else $error("vector index wrong");
	a_pc_load: assert property (vec_rd_req && vec_rd_valid |=>
		pc_load_valid && flow_ctx_clear && pc_load_addr == $past(vec_rd_data))
		else $error("routine load wrong");
	a_reset_vals: assert property (rst_acc |=> sw_reset_done &&
		global_irq_mask && status_word_zero == 16'h3800 &&
		status_word_one == 16'h2920 && status_word_two == 16'h1000 &&
		temp_reg_two == 16'h0000 && $stable(status_word_three))
		else $error("soft reset values wrong");
	a_refused: assert property (bad_acc |=> repeat_refused &&
		!data_stack_wr.we && !sw_reset_done)
		else $error("repeat not refused");
endmodule

bind soft_interrupt_reset_unit sirst_chk chk_i (.clk_sys, .rst, .dec_valid,
	.dec_req, .dec_ready, .vec_rd_req, .vec_rd_addr, .vec_rd_valid,
	.vec_rd_data, .data_stack_wr, .sys_stack_wr, .pc_load_valid,
	.pc_load_addr, .flow_ctx_clear, .repeat_refused, .sw_reset_done,
	.global_irq_mask, .status_word_zero, .status_word_one, .status_word_two,
	.status_word_three, .temp_reg_two);

// *** bench/vec_mem_model.sv ***
// Vector memory model answering the unit's vector reads.
// Assumes the unit holds vec_rd_req until it sees vec_rd_valid.
module vec_mem_model (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          vec_rd_req,
	input  wire logic [23:0]   vec_rd_addr,
	input  wire logic [3:0]    dly,
	output logic               vec_rd_valid,
	output logic [23:0]        vec_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	// Idle data toggles so a stale word never passes for an answer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			vec_rd_valid <= 1'b0;
			vec_rd_data <= 24'h000000;
		end else if (vec_rd_req && !vec_rd_valid && cnt_r == dly) begin
			cnt_r <= 4'h0;
			vec_rd_valid <= 1'b1;
			vec_rd_data <= vec_rd_addr ^ 24'h5A5A5A;
		end else begin
			cnt_r <= (vec_rd_req && !vec_rd_valid) ? cnt_r + 4'h1 : 4'h0;
			vec_rd_valid <= 1'b0;
			vec_rd_data <= ~vec_rd_data;
		end
	end
endmodule

// *** bench/soft_interrupt_reset_unit_tb_top.sv ***
// Self-checking bench for the software interrupt/reset unit.
// Assumes the vector memory model and the bound checker.
module soft_interrupt_reset_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk_sys = 1'b0;
	logic                 rst = 1'b1;
	logic [5:0]           address = 6'h00;
	logic                 read = 1'b0;
	logic                 write = 1'b0;
	logic [3:0]           byteenable = 4'hF;
	logic [31:0]          writedata = 32'h0;
	logic [31:0]          readdata, irq_raise = 32'h0;
	logic                 waitrequest, dec_ready, dec_valid = 1'b0;
	sirst_pkg::dec_req_t  dec_req = 50'h0;
	logic                 vec_rd_req, vec_rd_valid, pc_load_valid;
	logic [23:0]          vec_rd_addr, vec_rd_data, pc_load_addr, pl;
	sirst_pkg::stack_wr_t data_stack_wr, sys_stack_wr;
	logic                 flow_ctx_clear, repeat_refused, sw_reset_done;
	logic                 global_irq_mask;
	logic [15:0]          status_word_zero, status_word_one, status_word_two;
	logic [15:0]          status_word_three, temp_reg_two;
	logic [3:0]           dly = 4'h0;
	logic [31:0]          dq[$], sq[$];
	int                   npl = 0, nsr = 0, nrf = 0;
	int                   miscompares = 0, compares = 0;
	soft_interrupt_reset_unit uut (.clk_sys, .rst, .address, .read, .write,
		.byteenable, .writedata, .readdata, .waitrequest, .dec_valid,
		.dec_req, .dec_ready, .irq_raise, .vec_rd_req, .vec_rd_addr,
		.vec_rd_valid, .vec_rd_data, .data_stack_wr, .sys_stack_wr,
		.pc_load_valid, .pc_load_addr, .flow_ctx_clear, .repeat_refused,
		.sw_reset_done, .global_irq_mask, .status_word_zero,
		.status_word_one, .status_word_two, .status_word_three,
		.temp_reg_two);
	vec_mem_model mem (.clk_sys, .rst, .vec_rd_req, .vec_rd_addr, .dly,
		.vec_rd_valid, .vec_rd_data);
	always #2 clk_sys = ~clk_sys;
	// Pushes and pulses logged at the edge they stand
	always @(posedge clk_sys) begin
		if (data_stack_wr.we)
			dq.push_back({data_stack_wr.addr, data_stack_wr.data});
		if (sys_stack_wr.we)
			sq.push_back({sys_stack_wr.addr, sys_stack_wr.data});
		if (pc_load_valid)
			pl = pc_load_addr;
		npl += int'(pc_load_valid);
		nsr += int'(sw_reset_done);
		nrf += int'(repeat_refused);
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Read data taken only at the rising edge waitrequest is low
	task automatic bus(logic w, logic [5:0] a, logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(logic [5:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(string n, logic [5:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask
	task automatic pulse(logic [31:0] v);
		@(posedge clk_sys);
		irq_raise <= v;
		@(posedge clk_sys);
		irq_raise <= 32'h0;
	endtask
	task automatic issue(logic [15:0] op, logic rp, logic pr);
		@(posedge clk_sys);
		dec_valid <= 1'b1;
		dec_req <= {op, 24'hABCDEF, 8'h5A, rp, pr};
		@(posedge clk_sys);
		dec_valid <= 1'b0;
	endtask
	task automatic wait_for(ref int c, input int n0);
		for (int i = 0; i < 40 && c == n0; i++)
			@(negedge clk_sys);
	endtask
	task automatic t_reset();
		chk("st0", 32'h3800, {16'h0, status_word_zero});
		chk("mask", 32'h1, {31'h0, global_irq_mask});
		rdc("st1 reg", 6'h08, 32'h2920);
		rdc("st2 reg", 6'h0C, 32'h1000);
		rdc("temp2", 6'h2C, 32'h0);
		rdc("unmapped", 6'h3C, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_swi(logic [4:0] i, logic f, logic [15:0] s1,
		logic [3:0] d);
		logic [23:0] va;
		int          n0;
		va = {i[4] ? 16'h4560 : 16'h1230, i, 3'h0};
		dly <= d;
		wr(6'h00, {31'h0, f});
		wr(6'h30, 32'h0100);
		wr(6'h34, 32'h0200);
		wr(6'h1C, 32'h1230);
		wr(6'h20, 32'h4560);
		wr(6'h24, 32'hBEEF);
		wr(6'h08, {16'h0, s1});
		pulse((32'h1 << i) | (32'h1 << (i ^ 5'h01)));
		dq.delete();
		sq.delete();
		n0 = npl;
		issue({11'h4A8, i}, 1'b0, 1'b0);
		wait_for(npl, n0);
		chk("routine", {8'h0, va ^ 24'h5A5A5A}, {8'h0, pl});
		chk("data push 1", 32'h00FF1000, dq[0]);
		chk("sys push 1", 32'h01FF3800, sq[0]);
		chk("data push 2", {16'h00FE, s1}, dq[1]);
		chk("sys push 2", 32'h01FEBEEF, sq[1]);
		if (f) begin
			chk("pushes", 32'd2, dq.size());
			rdc("ret pair", 6'h28, 32'h5AABCDEF);
		end else begin
			chk("data push 3", 32'h00FDCDEF, dq[2]);
			chk("sys push 3", 32'h01FD5AAB, sq[2]);
		end
		chk("mask", 32'h1, {31'h0, global_irq_mask});
		rdc("flags", i[4] ? 6'h18 : 6'h14, 32'h4);
		rdc("sp", 6'h30, f ? 32'h00FE : 32'h00FD);
		$display("test interrupt %h done", i);
	endtask
	task automatic t_swrst();
		int n0;
		wr(6'h04, 32'h07FF);
		wr(6'h08, 32'h0);
		wr(6'h0C, 32'h00FF);
		wr(6'h10, 32'h00A5);
		wr(6'h2C, 32'hFFFF);
		pulse(32'hFFFFFFFF);
		n0 = nsr;
		issue(16'h94C3, 1'b0, 1'b0);
		wait_for(nsr, n0);
		chk("st0", 32'h3800, {16'h0, status_word_zero});
		chk("st1", 32'h2920, {16'h0, status_word_one});
		chk("st2", 32'h1000, {16'h0, status_word_two});
		chk("temp2", 32'h0, {16'h0, temp_reg_two});
		chk("st3", 32'h00A5, {16'h0, status_word_three});
		rdc("vptr", 6'h1C, 32'h1230);
		rdc("flags low", 6'h14, 32'h0);
		rdc("flags high", 6'h18, 32'h0);
		$display("test soft reset done");
	endtask
	task automatic t_refuse();
		int n0;
		int n1;
		wr(6'h08, 32'h2120);
		dq.delete();
		n0 = nrf;
		n1 = nsr;
		issue(16'h9503, 1'b1, 1'b0);
		wait_for(nrf, n0);
		issue(16'h9400, 1'b0, 1'b1);
		wait_for(nrf, n0 + 1);
		chk("refusals", n0 + 2, nrf);
		chk("pushes", 32'h0, dq.size());
		chk("resets", n1, nsr);
		chk("st1", 32'h2120, {16'h0, status_word_one});
		$display("test refusal done");
	endtask
	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_swi(5'h03, 1'b0, 16'h2120, 4'h0);
		t_swi(5'h13, 1'b1, 16'h2920, 4'h5);
		t_swrst();
		t_refuse();
		stop_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		miscompares++;
		stop_test();
	end
endmodule
